// file: design/iau_regs.svh
// Register offsets, field positions, reset values and timing counts of the interrupt unit
// Summary of operation
// - Three sources: pin edge, timer underflow or capture, non-maskable opcode zero.
// - Maskable interrupts need the global enable plus their own source enable.
// - Acknowledging a hardware interrupt clears the global enable.
// - Pin enable gates the pin source, timer enable gates the timer source.
// - Edge select 0 takes rising pin edges, 1 takes falling edges.
// - Separate pin and timer pending flags; only software clears them.
// - Setting global enable inside a service routine allows nested interrupts.
// - Software interrupt acknowledge leaves the global enable unchanged.
// - Acknowledge pushes the program counter and lowers the stack pointer by two.
// - Execution continues at 00FF; the acknowledge takes 7 cycles.
// - All three returns pop the program counter, then raise stack pointer by two.
// - The return-and-enable instruction also sets the global enable.
// - Unimplemented program memory reads as 00, which is the trap opcode.
// - Unimplemented data memory reads as FF, so unbalanced returns reach 7FFF.
// - The stack grows downward in data memory.
// - Master reset clears program counter, status word and control register.
// - Timer pending is set by underflow outside capture mode, and only by capture edge in capture mode.
`ifndef IAU_REGS_SVH
`define IAU_REGS_SVH
`define IAU_OFS_CONTROL 12'h000
`define IAU_OFS_STATUS 12'h004
`define IAU_OFS_STACK 12'h008
`define IAU_OFS_PC 12'h00C
`define IAU_BIT_EDGE 2
`define IAU_BIT_GLOBAL_EN 0
`define IAU_BIT_PIN_EN 1
`define IAU_BIT_PIN_PEND 3
`define IAU_BIT_TIMER_EN 4
`define IAU_BIT_TIMER_PEND 5
`define IAU_STATUS_MASK 8'h3B
`define IAU_RESET_BYTE 8'h00
`define IAU_RESET_PC 15'h0000
`define IAU_RESET_SP 8'h00
`define IAU_VECTOR 15'h00FF
`define IAU_ACK_CYCLES 3'h7
`define IAU_ROM_BYTES 15'h0400
`define IAU_RAM_BYTES 8'h40
`define IAU_ROM_BLANK 8'h00
`define IAU_RAM_BLANK 8'hFF
`define IAU_CAPTURE_MODE 2'h3
`define IAU_RESP_OKAY 2'h0
`define IAU_RESP_SLVERR 2'h2
`endif

// file: design/iau_pkg.sv
// Types shared by the interrupt unit
package iau_pkg;
   typedef enum logic [2:0] {
      IAU_IDLE = 3'b000,
      IAU_ACK = 3'b001,
      IAU_RET_ADDR = 3'b010,
      IAU_RET_HIGH = 3'b011,
      IAU_RET_LOW = 3'b100
   } iau_state_e;
   typedef enum logic [1:0] {
      IAU_PLAIN_RETURN = 2'b00,
      IAU_RETURN_AND_SKIP = 2'b01,
      IAU_RETURN_AND_ENABLE = 2'b10
   } iau_ret_kind_e;
endpackage

// file: design/iau_interrupt_unit.sv
// Interrupt, stack sequencing and illegal-condition unit with an AXI4-Lite register slave
//
// Implementation choices: the address map and the AXI4-Lite interface to the registers.
`include "iau_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module iau_interrupt_unit (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Interrupt sources
   input wire logic external_irq_pin,
   input wire logic timer_underflow,
   input wire logic timer_capture_edge,
   output logic [7:0] timer_serial_control,
   // Sequencer
   input wire logic instr_boundary,
   input wire logic pc_advance,
   input wire logic pc_load,
   input wire logic [14:0] pc_load_value,
   input wire logic ret_req,
   input wire iau_pkg::iau_ret_kind_e ret_kind,
   output logic seq_busy,
   output logic [14:0] program_counter,
   // Program memory fetch
   input wire logic fetch_strobe,
   input wire logic [7:0] rom_raw_data,
   output logic [7:0] fetch_opcode,
   // Data memory stack port
   output logic ram_wr_en,
   output logic ram_rd_en,
   output logic [7:0] ram_addr,
   output logic [7:0] ram_wdata,
   input wire logic [7:0] ram_raw_data
);
   import iau_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Memory filters for unimplemented locations

   function automatic logic [7:0] rom_filter(input logic [14:0] a, input logic [7:0] d);
      rom_filter = (a < `IAU_ROM_BYTES) ? d : `IAU_ROM_BLANK;
   endfunction

   function automatic logic [7:0] ram_filter(input logic [7:0] a, input logic [7:0] d);
      ram_filter = (a < `IAU_RAM_BYTES) ? d : `IAU_RAM_BLANK;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // State

   iau_state_e state_q, state_d;
   logic [7:0] control_q;
   logic global_irq_enable_q, pin_irq_enable_q, timer_irq_enable_q;
   logic pin_irq_pending_q, timer_irq_pending_q;
   logic [7:0] sp_q;
   logic [14:0] pc_q;
   logic [2:0] ack_cnt_q;
   logic [1:0] ret_kind_q;
   logic [7:0] ret_high_q, rd_addr_q, opcode_q;
   logic pin_prev_q, trap_q;
   logic wr_en_q, rd_en_q;
   logic [7:0] addr_q, wdata_q;

   ////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite slave

   logic aw_held_q, w_held_q, bvalid_q, rvalid_q;
   logic [11:0] awaddr_q;
   logic [7:0] wbyte_q;
   logic wstrb0_q;
   logic [1:0] bresp_q, rresp_q;
   logic [31:0] rdata_q;

   wire aw_take = s_axi_awvalid && !aw_held_q && !bvalid_q;
   wire w_take = s_axi_wvalid && !w_held_q && !bvalid_q;
   wire wr_fire = aw_held_q && w_held_q && !bvalid_q;
   wire wr_ctrl = wr_fire && wstrb0_q && awaddr_q == `IAU_OFS_CONTROL;
   wire wr_stat = wr_fire && wstrb0_q && awaddr_q == `IAU_OFS_STATUS;
   wire wr_sp = wr_fire && wstrb0_q && awaddr_q == `IAU_OFS_STACK;
   wire wr_mapped = awaddr_q == `IAU_OFS_CONTROL || awaddr_q == `IAU_OFS_STATUS ||
      awaddr_q == `IAU_OFS_STACK || awaddr_q == `IAU_OFS_PC;
   wire rd_fire = s_axi_arvalid && !rvalid_q;

   wire [7:0] status_word = {2'b00, timer_irq_pending_q, timer_irq_enable_q, pin_irq_pending_q,
      1'b0, pin_irq_enable_q, global_irq_enable_q};
   wire [31:0] rd_value =
      (s_axi_araddr == `IAU_OFS_CONTROL) ? {24'h000000, control_q} :
      (s_axi_araddr == `IAU_OFS_STATUS) ? {24'h000000, status_word} :
      (s_axi_araddr == `IAU_OFS_STACK) ? {24'h000000, sp_q} :
      (s_axi_araddr == `IAU_OFS_PC) ? {17'h00000, pc_q} : 32'h00000000;
   wire rd_mapped = s_axi_araddr == `IAU_OFS_CONTROL || s_axi_araddr == `IAU_OFS_STATUS ||
      s_axi_araddr == `IAU_OFS_STACK || s_axi_araddr == `IAU_OFS_PC;

   assign s_axi_awready = !aw_held_q && !bvalid_q;
   assign s_axi_wready = !w_held_q && !bvalid_q;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;
   assign s_axi_arready = !rvalid_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_q <= 1'b0;
         w_held_q <= 1'b0;
         bvalid_q <= 1'b0;
         awaddr_q <= 12'h000;
         wbyte_q <= 8'h00;
         wstrb0_q <= 1'b0;
         bresp_q <= `IAU_RESP_OKAY;
      end else begin
         if (aw_take) begin
            aw_held_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
         end
         if (w_take) begin
            w_held_q <= 1'b1;
            wbyte_q <= s_axi_wdata[7:0];
            wstrb0_q <= s_axi_wstrb[0];
         end
         if (wr_fire) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            bvalid_q <= 1'b1;
            bresp_q <= wr_mapped ? `IAU_RESP_OKAY : `IAU_RESP_SLVERR;
         end else if (bvalid_q && s_axi_bready) begin
            bvalid_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_q <= 1'b0;
         rdata_q <= 32'h00000000;
         rresp_q <= `IAU_RESP_OKAY;
      end else if (rd_fire) begin
         rvalid_q <= 1'b1;
         rdata_q <= rd_value;
         rresp_q <= rd_mapped ? `IAU_RESP_OKAY : `IAU_RESP_SLVERR;
      end else if (rvalid_q && s_axi_rready) begin
         rvalid_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Event detection

   wire edge_sel = control_q[`IAU_BIT_EDGE];
   wire pin_edge = edge_sel ? (pin_prev_q && !external_irq_pin)
                            : (!pin_prev_q && external_irq_pin);
   wire capture_mode = control_q[7:6] == `IAU_CAPTURE_MODE;
   wire timer_event = capture_mode ? timer_capture_edge : timer_underflow;
   wire [7:0] fetched = rom_filter(pc_q, rom_raw_data);
   wire trap_now = fetch_strobe && fetched == 8'h00;

   // Maskable request: both the global and the source enable are needed
   wire mask_req = global_irq_enable_q && ((pin_irq_enable_q && pin_irq_pending_q) ||
      (timer_irq_enable_q && timer_irq_pending_q));
   wire take_irq = state_q == IAU_IDLE && instr_boundary && (mask_req || trap_q);
   wire take_ret = state_q == IAU_IDLE && !take_irq && ret_req;
   wire ack_done = state_q == IAU_ACK && ack_cnt_q == `IAU_ACK_CYCLES - 3'h1;
   wire ret_done = state_q == IAU_RET_LOW;
   wire [7:0] rd_filtered = ram_filter(rd_addr_q, ram_raw_data);
   wire [15:0] popped = {ret_high_q, rd_filtered};

   ////////////////////////////////////////////////////////////////////////////
   // Sequencer

   always_comb begin
      state_d = state_q;
      case (state_q)
         IAU_IDLE: begin
            if (take_irq) begin
               state_d = IAU_ACK;
            end else if (take_ret) begin
               state_d = IAU_RET_ADDR;
            end
         end
         IAU_ACK: begin
            if (ack_done) begin
               state_d = IAU_IDLE;
            end
         end
         IAU_RET_ADDR: state_d = IAU_RET_HIGH;
         IAU_RET_HIGH: state_d = IAU_RET_LOW;
         IAU_RET_LOW: state_d = IAU_IDLE;
         default: state_d = IAU_IDLE;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_q <= IAU_IDLE;
         ack_cnt_q <= 3'h0;
         ret_kind_q <= IAU_PLAIN_RETURN;
      end else begin
         state_q <= state_d;
         ack_cnt_q <= (state_q == IAU_ACK) ? ack_cnt_q + 3'h1 : 3'h0;
         if (take_ret) begin
            ret_kind_q <= ret_kind;
         end
      end
   end

   // Stack traffic: push low then high byte walking down, pop walks back up
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wr_en_q <= 1'b0;
         rd_en_q <= 1'b0;
         addr_q <= 8'h00;
         wdata_q <= 8'h00;
         rd_addr_q <= 8'h00;
         ret_high_q <= 8'h00;
      end else begin
         wr_en_q <= 1'b0;
         rd_en_q <= 1'b0;
         if (take_irq) begin
            wr_en_q <= 1'b1;
            addr_q <= sp_q;
            wdata_q <= pc_q[7:0];
         end else if (state_q == IAU_ACK && ack_cnt_q == 3'h0) begin
            wr_en_q <= 1'b1;
            addr_q <= sp_q - 8'h01;
            wdata_q <= {1'b0, pc_q[14:8]};
         end else if (take_ret) begin
            rd_en_q <= 1'b1;
            addr_q <= sp_q + 8'h01;
         end else if (state_q == IAU_RET_ADDR) begin
            rd_en_q <= 1'b1;
            addr_q <= sp_q + 8'h02;
         end
         if (rd_en_q) begin
            rd_addr_q <= addr_q;
         end
         if (state_q == IAU_RET_HIGH) begin
            ret_high_q <= rd_filtered;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Program counter, stack pointer, fetch

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pc_q <= `IAU_RESET_PC;
         sp_q <= `IAU_RESET_SP;
         opcode_q <= 8'h00;
         trap_q <= 1'b0;
         pin_prev_q <= external_irq_pin; // Follow the pin so no false edge follows reset
      end else begin
         pin_prev_q <= external_irq_pin;
         if (fetch_strobe) begin
            opcode_q <= fetched;
         end
         if (take_irq) begin
            trap_q <= trap_now;
         end else if (trap_now) begin
            trap_q <= 1'b1;
         end
         if (ack_done) begin
            pc_q <= `IAU_VECTOR;
            sp_q <= sp_q - 8'h02;
         end else if (ret_done) begin
            sp_q <= sp_q + 8'h02;
            pc_q <= (ret_kind_q == IAU_RETURN_AND_SKIP) ? popped[14:0] + 15'h0001 : popped[14:0];
         end else begin
            if (wr_sp) begin
               sp_q <= wbyte_q;
            end
            if (pc_load) begin
               pc_q <= pc_load_value;
            end else if (pc_advance) begin
               pc_q <= pc_q + 15'h0001;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Control and status word

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         control_q <= `IAU_RESET_BYTE;
         global_irq_enable_q <= 1'b0;
         pin_irq_enable_q <= 1'b0;
         timer_irq_enable_q <= 1'b0;
         pin_irq_pending_q <= 1'b0;
         timer_irq_pending_q <= 1'b0;
      end else begin
         if (wr_ctrl) begin
            control_q <= wbyte_q;
         end
         if (wr_stat) begin
            pin_irq_enable_q <= wbyte_q[`IAU_BIT_PIN_EN];
            timer_irq_enable_q <= wbyte_q[`IAU_BIT_TIMER_EN];
         end
         // Pending: a new event wins over a software clear
         pin_irq_pending_q <= (wr_stat ? wbyte_q[`IAU_BIT_PIN_PEND] : pin_irq_pending_q) |
            pin_edge;
         timer_irq_pending_q <= (wr_stat ? wbyte_q[`IAU_BIT_TIMER_PEND] : timer_irq_pending_q) |
            timer_event;
         if (take_irq && mask_req) begin
            global_irq_enable_q <= 1'b0;
         end else if (ret_done && ret_kind_q == IAU_RETURN_AND_ENABLE) begin
            global_irq_enable_q <= 1'b1;
         end else if (wr_stat) begin
            global_irq_enable_q <= wbyte_q[`IAU_BIT_GLOBAL_EN];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs

   assign seq_busy = state_q != IAU_IDLE;
   assign program_counter = pc_q;
   assign fetch_opcode = opcode_q;
   assign timer_serial_control = control_q;
   assign ram_wr_en = wr_en_q;
   assign ram_rd_en = rd_en_q;
   assign ram_addr = addr_q;
   assign ram_wdata = wdata_q;
endmodule
`default_nettype wire

// file: verif/iau_assertions.sv
// Port assertions for the interrupt unit and their bind
`timescale 1ns/1ps
`default_nettype none
module iau_checker (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Bus answers
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   // Sequencer and memories
   input wire logic seq_busy,
   input wire logic [14:0] program_counter,
   input wire logic fetch_strobe,
   input wire logic [7:0] fetch_opcode,
   input wire logic ram_wr_en,
   input wire logic ram_rd_en,
   input wire logic [7:0] ram_addr,
   input wire logic [7:0] ram_wdata
);
   logic [3:0] busy_cnt_q;
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   always_ff @(posedge aclk) begin
      busy_cnt_q <= (!aresetn || !seq_busy) ? 4'h0 : busy_cnt_q + 4'h1;
   end
   ////////////////////////////////////////////////////////////////
   ack_len_a: assert property ($fell(seq_busy) |-> busy_cnt_q == 4'h7 || busy_cnt_q == 4'h3)
      else $error("busy run length wrong");
   ack_stack_a: assert property (ram_wr_en && !$past(ram_wr_en) |->
      ram_wdata == program_counter[7:0] ##1 ram_wr_en && ram_addr == $past(ram_addr) - 8'h01
      && ram_wdata == {1'b0, program_counter[14:8]}) else $error("stacked bytes wrong");
   ack_vector_a: assert property (ram_wr_en && !$past(ram_wr_en) |->
      ##[1:7] $fell(seq_busy) && program_counter == 15'h00FF) else $error("vector missed");
   strobe_busy_a: assert property (ram_wr_en || ram_rd_en |-> seq_busy && !(ram_wr_en && ram_rd_en))
      else $error("stray memory strobe");
   ret_pop_a: assert property (ram_rd_en && !$past(ram_rd_en) |->
      ##1 ram_rd_en && ram_addr == $past(ram_addr) + 8'h01 ##1 !ram_rd_en) else $error("pop wrong");
   ret_end_a: assert property (ram_rd_en ##1 ram_rd_en |-> ##[1:2] $fell(seq_busy))
      else $error("return too long");
   blank_rom_a: assert property (fetch_strobe && program_counter >= 15'h0400 |=>
      fetch_opcode == 8'h00) else $error("blank fetch not zero");
   bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write answer dropped");
   rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read answer dropped");
   ack_c: cover property (ram_wr_en ##1 ram_wr_en);
   ret_c: cover property (ram_rd_en ##1 ram_rd_en);
   trap_c: cover property (fetch_strobe && program_counter >= 15'h0400);
endmodule
bind iau_interrupt_unit iau_checker i_chk (.aclk(aclk), .aresetn(aresetn),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
   .seq_busy(seq_busy), .program_counter(program_counter), .fetch_strobe(fetch_strobe),
   .fetch_opcode(fetch_opcode), .ram_wr_en(ram_wr_en), .ram_rd_en(ram_rd_en),
   .ram_addr(ram_addr), .ram_wdata(ram_wdata));
`default_nettype wire

// file: verif/iau_mem_model.sv
// Behavioural stack RAM and program ROM beside the interrupt unit
`timescale 1ns/1ps
`default_nettype none
module iau_mem_model (
   // Clock
   input wire logic aclk,
   // Program memory
   input wire logic [14:0] program_counter,
   output logic [7:0] rom_raw_data,
   // Stack memory
   input wire logic ram_wr_en,
   input wire logic ram_rd_en,
   input wire logic [7:0] ram_addr,
   input wire logic [7:0] ram_wdata,
   output var logic [7:0] ram_raw_data = 8'h5A
);
   logic [7:0] mem [64];
   // Raw ROM never reads zero, so a zero opcode can only come from the filter
   assign rom_raw_data = program_counter[7:0] | 8'h01;
   always @(posedge aclk) begin
      if (ram_wr_en && ram_addr < 8'h40) begin
         mem[ram_addr[5:0]] <= ram_wdata;
      end
      // Nothing drives the bus outside the implemented range or between reads
      ram_raw_data <= (ram_rd_en && ram_addr < 8'h40) ? mem[ram_addr[5:0]] : ~ram_raw_data;
   end
endmodule
`default_nettype wire

// file: verif/tb_top.sv
// Self-checking bench for the interrupt unit
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import iau_pkg::*;
   typedef struct {logic [11:0] a; logic [31:0] w; logic [31:0] rd; logic [1:0] rs;} iau_row_s;
   iau_row_s rows [5] = '{'{12'h000, 32'hC0, 32'hC0, 2'h0}, '{12'h004, 32'h12, 32'h12, 2'h0},
      '{12'h008, 32'h3F, 32'h3F, 2'h0}, '{12'h00C, 32'h55, 32'h0, 2'h0}, '{12'h010, 32'h1, 32'h0, 2'h2}};
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, rs;
   logic external_irq_pin = 1'b1, timer_underflow = 1'b0, timer_capture_edge = 1'b0;
   logic instr_boundary = 1'b1, pc_advance = 1'b0, pc_load = 1'b0, ret_req = 1'b0;
   logic fetch_strobe = 1'b0, seq_busy, ram_wr_en, ram_rd_en;
   logic [14:0] pc_load_value = 15'h0, program_counter;
   iau_ret_kind_e ret_kind = IAU_PLAIN_RETURN;
   logic [7:0] timer_serial_control, rom_raw_data, fetch_opcode, ram_addr, ram_wdata, ram_raw_data;
   int err_total = 0, checks_done = 0, cyc_cnt = 0, i;
   iau_interrupt_unit i_dut (.*);
   iau_mem_model i_mem (.*);
   always #10 aclk = ~aclk;
   ////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         $display("Error at %0t: got %h expected %h", $time, got, exp);
         err_total++;
      end
   endtask
   // Ready is raised one edge after valid so the slave's hold of its answer is exercised
   task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid && !s_axi_bready) s_axi_bready <= 1'b1;
      end while (!(s_axi_bvalid && s_axi_bready));
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid && !s_axi_rready) s_axi_rready <= 1'b1;
      end while (!(s_axi_rvalid && s_axi_rready));
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   task automatic reg_chk(input logic [11:0] a, input logic [31:0] exp);
      axi_rd(a, rd, rs);
      chk(rd, exp);
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      axi_wr(a, d, rs);
   endtask
   task automatic seq_run();
      int n;
      n = 0;
      while (!seq_busy && n < 8) begin
         @(posedge aclk);
         n++;
      end
      chk(seq_busy, 1'b1);
      while (seq_busy && n < 40) begin
         @(posedge aclk);
         n++;
      end
   endtask
   task automatic do_ret(input iau_ret_kind_e k);
      ret_req <= 1'b1;
      ret_kind <= k;
      @(posedge aclk);
      ret_req <= 1'b0;
      seq_run();
   endtask
   task automatic give_verdict();
      if (err_total == 0 && checks_done > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   always @(posedge aclk) begin
      cyc_cnt++;
      if (cyc_cnt == 20000) begin
         err_total++;
         give_verdict();
      end
   end
   ////////////////////////////////////////////////////////////////
   initial begin
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      for (i = 0; i < 4; i++) reg_chk(12'(i * 4), 32'h0);
      for (i = 0; i < 5; i++) begin
         axi_wr(rows[i].a, rows[i].w, rs);
         chk(rs, rows[i].rs);
         axi_rd(rows[i].a, rd, rs);
         chk(rd, rows[i].rd);
         chk(rs, rows[i].rs);
      end
      wr(12'h000, 32'hC4);
      external_irq_pin <= 1'b0;
      repeat (4) @(posedge aclk);
      chk(seq_busy, 1'b0);
      reg_chk(12'h004, 32'h1A);
      wr(12'h004, 32'h12);
      external_irq_pin <= 1'b1;
      repeat (4) @(posedge aclk);
      reg_chk(12'h004, 32'h12);
      pc_load <= 1'b1;
      pc_load_value <= 15'h0123;
      external_irq_pin <= 1'b0;
      @(posedge aclk);
      pc_load <= 1'b0;
      wr(12'h004, 32'h1B);
      seq_run();
      chk(program_counter, 15'h00FF);
      reg_chk(12'h004, 32'h1A);
      reg_chk(12'h008, 32'h3D);
      chk(i_mem.mem[63], 8'h23);
      chk(i_mem.mem[62], 8'h01);
      wr(12'h004, 32'h12);
      do_ret(IAU_RETURN_AND_ENABLE);
      chk(program_counter, 15'h0123);
      reg_chk(12'h004, 32'h13);
      pc_load <= 1'b1;
      pc_load_value <= 15'h0400;
      @(posedge aclk);
      pc_load <= 1'b0;
      fetch_strobe <= 1'b1;
      @(posedge aclk);
      fetch_strobe <= 1'b0;
      seq_run();
      chk(program_counter, 15'h00FF);
      reg_chk(12'h004, 32'h13);
      do_ret(IAU_RETURN_AND_SKIP);
      chk(program_counter, 15'h0401);
      wr(12'h004, 32'h10);
      timer_underflow <= 1'b1;
      @(posedge aclk);
      timer_underflow <= 1'b0;
      reg_chk(12'h004, 32'h10);
      timer_capture_edge <= 1'b1;
      @(posedge aclk);
      timer_capture_edge <= 1'b0;
      reg_chk(12'h004, 32'h30);
      wr(12'h004, 32'h31);
      seq_run();
      reg_chk(12'h004, 32'h30);
      wr(12'h004, 32'h00);
      wr(12'h008, 32'h3F);
      do_ret(IAU_PLAIN_RETURN);
      chk(program_counter, 15'h7FFF);
      reg_chk(12'h008, 32'h41);
      // Timer mode without capture: underflow is the source, held off until a boundary
      wr(12'h000, 32'h80);
      instr_boundary <= 1'b0;
      wr(12'h004, 32'h11);
      timer_underflow <= 1'b1;
      @(posedge aclk);
      timer_underflow <= 1'b0;
      repeat (4) @(posedge aclk);
      chk(seq_busy, 1'b0);
      reg_chk(12'h004, 32'h31);
      instr_boundary <= 1'b1;
      seq_run();
      reg_chk(12'h004, 32'h30);
      give_verdict();
   end
endmodule
`default_nettype wire
